// file: src/acrm_pkg.sv
// acrm_pkg: register map constants and types for the converter configuration bank
// assumes: single package shared by the serial front end and the register bank
package acrm_pkg;

    // register byte addresses
    localparam logic [11:0] ADDR_SP_CFG_A   = 12'h000;
    localparam logic [11:0] ADDR_SP_CFG_B   = 12'h001;
    localparam logic [11:0] ADDR_PWR_STATE  = 12'h002;
    localparam logic [11:0] ADDR_FAMILY     = 12'h003;
    localparam logic [11:0] ADDR_PART_LO    = 12'h004;
    localparam logic [11:0] ADDR_PART_HI    = 12'h005;
    localparam logic [11:0] ADDR_GRADE      = 12'h006;
    localparam logic [11:0] ADDR_CHAN_SEL   = 12'h008;
    localparam logic [11:0] ADDR_OUT_MODE   = 12'h561;

    // reset values
    localparam logic [7:0] RST_SP_CFG_A     = 8'h00;
    localparam logic [7:0] RST_SP_CFG_B     = 8'h00;
    localparam logic [7:0] RST_PWR_STATE    = 8'h00;
    localparam logic [1:0] RST_CHAN_SEL     = 2'h3;
    localparam logic [7:0] RST_OUT_MODE     = 8'h01;

    // identity bytes: arbitrary neutral values
    localparam logic [7:0] ID_FAMILY        = 8'h0A;
    localparam logic [7:0] ID_PART_LO       = 8'h5C;
    localparam logic [7:0] ID_PART_HI       = 8'h01;
    localparam logic [7:0] ID_GRADE         = 8'h20;

    // soft reset trigger and field positions
    localparam logic [7:0] SOFT_RESET_CODE  = 8'h81;
    localparam int         BIT_SR_LO        = 0;
    localparam int         BIT_SR_HI        = 7;
    localparam int         BIT_LSBF_LO      = 1;
    localparam int         BIT_LSBF_HI      = 6;
    localparam int         BIT_ASC_LO       = 2;
    localparam int         BIT_ASC_HI       = 5;
    localparam int         BIT_SINGLE_INS   = 7;
    localparam int         BIT_DP_RESET     = 1;
    localparam logic [7:0] MASK_SP_CFG_B    = 8'h80;
    localparam logic [7:0] MASK_OUT_MODE    = 8'h0F;
    localparam logic [7:0] MASK_PWR         = 8'h03;
    localparam int         NUM_CHAN         = 2;

    // power-state encodings
    localparam logic [1:0] PWR_NORMAL       = 2'h0;
    localparam logic [1:0] PWR_STANDBY      = 2'h2;
    localparam logic [1:0] PWR_DOWN         = 2'h3;

    // recovery time after soft reset
    localparam int         CORE_CLK_HZ      = 10_000_000;
    localparam int         SOFT_RST_US      = 5000;
    localparam int         SOFT_RST_CYC     = (SOFT_RST_US * (CORE_CLK_HZ / 1_000_000));

    // frame layout
    localparam int         INSTR_BITS       = 16;
    localparam int         DATA_BITS        = 8;

    // one completed register access handed from the serial side to the core
    typedef struct packed {
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } acrm_req_t;

    // per channel local settings
    typedef struct packed {
        logic [1:0]  pwr;
    } acrm_local_t;

    typedef enum logic [1:0] {
        ACRM_INSTR = 2'b00,
        ACRM_DATA  = 2'b01,
        ACRM_DONE  = 2'b11
    } acrm_sp_state_t;

endpackage

// file: src/acrm_sync_pulse.sv
// acrm_sync_pulse: toggle based event crossing into the destination clock
// assumes: source events spaced by at least three destination clock cycles;
// source clock may be stopped, so its toggle is cleared asynchronously
`timescale 1ns/1ps
module acrm_sync_pulse (
    // source side
    input  wire logic src_clk,
    input  wire logic src_rst,
    input  wire logic src_pulse,
    // destination side
    input  wire logic dst_clk,
    input  wire logic dst_rst,
    output logic      dst_pulse
);
    logic tgl_q;
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire  edge_seen = s2_q ^ s3_q;

    always_ff @(posedge src_clk or posedge src_rst) begin
        if (src_rst) tgl_q <= 1'b0;
        else if (src_pulse) tgl_q <= ~tgl_q;
    end

    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            dst_pulse <= 1'b0;
        end else begin
            s1_q      <= tgl_q;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            dst_pulse <= edge_seen;
        end
    end
endmodule

// file: src/acrm_regbank.sv
// acrm_regbank: configuration register bank behind a three-wire serial port
// assumes: host drives sclk, cs_n and sdio; sclk runs only while cs_n is low
//
// Functional notes
// - every reset loads all configuration registers with their defaults.
// - local registers have a separate copy per channel.
// - local accesses are steered by the two channel-select bits.
// - both select bits set: a local write updates both channels.
// - both select bits set: a local read returns channel A.
// - global registers keep one copy regardless of channel select.
// - writing 0x81 to primary config triggers full soft reset.
// - output mode register defaults to 0x01, two's complement.
`timescale 1ns/1ps
module acrm_regbank
    import acrm_pkg::*;
#(
    parameter int RECOVER_CYC = SOFT_RST_CYC
) (
    // core clock and reset
    input  wire logic       core_clk,
    input  wire logic       srst,
    // serial port, link clock domain
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe,
    // device state
    output logic [1:0]      pwr_state_a,
    output logic [1:0]      pwr_state_b,
    output logic [7:0]      out_mode,
    output logic            lsb_first,
    output logic            addr_ascend,
    output logic            recovering,
    output logic            datapath_reset
);

    // cs_n is the frame reset of the link domain
    wire link_rst = cs_n;

    // link side shifter
    acrm_sp_state_t   st_q;
    logic [4:0]       cnt_q;
    logic [INSTR_BITS-1:0] ins_q;
    logic [DATA_BITS-1:0]  wsh_q;
    logic [DATA_BITS-1:0]  rsh_q;
    acrm_req_t        req_q;
    logic             rd_q;

    // core side shadow of settings seen by the link (quasi static)
    logic             lsbf_core_q;
    logic [7:0]       rdata_core_q;

    wire [4:0]        cnt_ins = 5'(INSTR_BITS - 1);
    wire [4:0]        cnt_dat = 5'(DATA_BITS - 1);
    wire              bit_in  = sdio_i;
    wire              last_in = (cnt_q == cnt_ins);
    wire              last_dt = (cnt_q == cnt_dat);

    // link: capture on sclk rising edges, cs_n low frames the access
    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            st_q  <= ACRM_INSTR;
            cnt_q <= 5'h00;
            ins_q <= 16'h0000;
            wsh_q <= 8'h00;
            rd_q  <= 1'b0;
        end else begin
            case (st_q)
                ACRM_INSTR: begin
                    ins_q <= {ins_q[INSTR_BITS-2:0], bit_in};
                    cnt_q <= last_in ? 5'h00 : cnt_q + 5'h01;
                    if (last_in) begin
                        st_q <= ACRM_DATA;
                        rd_q <= ins_q[INSTR_BITS-2];
                    end
                end
                ACRM_DATA: begin
                    wsh_q <= lsbf_core_q ? {bit_in, wsh_q[DATA_BITS-1:1]}
                                         : {wsh_q[DATA_BITS-2:0], bit_in};
                    cnt_q <= last_dt ? 5'h00 : cnt_q + 5'h01;
                    if (last_dt) st_q <= ACRM_DONE;
                end
                ACRM_DONE: st_q <= ACRM_DONE;
                default:   st_q <= ACRM_INSTR;
            endcase
        end
    end

    // request word latched at end of data byte; the crossing cell marks the event
    wire      fire = (st_q == ACRM_DATA) && last_dt;
    wire [7:0] wbyte = lsbf_core_q ? {bit_in, wsh_q[DATA_BITS-1:1]}
                                   : {wsh_q[DATA_BITS-2:0], bit_in};
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            req_q     <= '0;
        end else if (fire) begin
            req_q     <= '{rd: rd_q, addr: ins_q[11:0], wdata: wbyte};
        end
    end

    // read data: loaded on falling edge after instruction, shifted out after
    wire rd_load = (st_q == ACRM_DATA) && (cnt_q == 5'h00);
    always_ff @(negedge sclk or posedge link_rst) begin
        if (link_rst) begin
            rsh_q   <= 8'h00;
            sdio_o  <= 1'b0;
            sdio_oe <= 1'b0;
        end else if (rd_load && rd_q) begin
            sdio_oe <= 1'b1;
            sdio_o  <= lsbf_core_q ? rdata_core_q[0] : rdata_core_q[7];
            rsh_q   <= lsbf_core_q ? {1'b0, rdata_core_q[7:1]} : {rdata_core_q[6:0], 1'b0};
        end else if (st_q == ACRM_DATA && rd_q) begin
            sdio_o  <= lsbf_core_q ? rsh_q[0] : rsh_q[7];
            rsh_q   <= lsbf_core_q ? {1'b0, rsh_q[7:1]} : {rsh_q[6:0], 1'b0};
        end else if (st_q == ACRM_DONE) begin
            sdio_oe <= 1'b0;
        end
    end

    // core: request event crosses as a toggle; the word itself stands until
    // the next frame, so it is read only after the event has arrived
    logic      req_ev;
    acrm_sync_pulse u_req_sync (
        .src_clk   (sclk),
        .src_rst   (srst),
        .src_pulse (fire),
        .dst_clk   (core_clk),
        .dst_rst   (srst),
        .dst_pulse (req_ev)
    );
    acrm_req_t req_c;
    assign req_c = req_q;

    // soft reset event
    logic      soft_rst_q;
    logic [$clog2(SOFT_RST_CYC+1)-1:0] rec_q;
    wire       bank_rst = srst | soft_rst_q;

    // registers
    logic [7:0]  cfg_a_q;
    logic        single_q;
    logic [NUM_CHAN-1:0] chsel_q;
    acrm_local_t loc_q [NUM_CHAN];
    logic [7:0]  omode_q;
    logic        dp_rst_q;

    wire         wr_ev  = req_ev && !req_c.rd && (rec_q == '0);
    wire         hit_a  = (req_c.addr == ADDR_SP_CFG_A);
    wire         hit_b  = (req_c.addr == ADDR_SP_CFG_B);
    wire         hit_p  = (req_c.addr == ADDR_PWR_STATE);
    wire         hit_s  = (req_c.addr == ADDR_CHAN_SEL);
    wire         hit_o  = (req_c.addr == ADDR_OUT_MODE);
    wire         sr_req = wr_ev && hit_a && (req_c.wdata == SOFT_RESET_CODE);
    // mirrored field view: take either half so both copies agree
    wire         lsbf_w = req_c.wdata[BIT_LSBF_LO] | req_c.wdata[BIT_LSBF_HI];
    wire         asc_w  = req_c.wdata[BIT_ASC_LO]  | req_c.wdata[BIT_ASC_HI];
    wire [7:0]   cfg_a_w = {1'b0, lsbf_w, asc_w, 2'b00, asc_w, lsbf_w, 1'b0};

    always_ff @(posedge core_clk) begin
        if (srst) begin
            soft_rst_q <= 1'b0;
            rec_q      <= '0;
        end else begin
            soft_rst_q <= sr_req;
            if (sr_req) rec_q <= ($clog2(SOFT_RST_CYC+1))'(RECOVER_CYC);
            else if (rec_q != '0) rec_q <= rec_q - 1'b1;
        end
    end

    // global registers: one copy each, channel select not consulted
    always_ff @(posedge core_clk) begin
        if (bank_rst) cfg_a_q <= RST_SP_CFG_A;
        else if (wr_ev && hit_a && !sr_req) cfg_a_q <= cfg_a_w;
    end

    always_ff @(posedge core_clk) begin
        if (bank_rst) single_q <= RST_SP_CFG_B[BIT_SINGLE_INS];
        else if (wr_ev && hit_b) single_q <= req_c.wdata[BIT_SINGLE_INS];
    end

    // self clearing: high for one cycle per write
    always_ff @(posedge core_clk) begin
        if (bank_rst) dp_rst_q <= 1'b0;
        else dp_rst_q <= wr_ev && hit_b && req_c.wdata[BIT_DP_RESET];
    end

    always_ff @(posedge core_clk) begin
        if (bank_rst) chsel_q <= RST_CHAN_SEL;
        else if (wr_ev && hit_s) chsel_q <= req_c.wdata[NUM_CHAN-1:0];
    end

    always_ff @(posedge core_clk) begin
        if (bank_rst) omode_q <= RST_OUT_MODE;
        else if (wr_ev && hit_o) omode_q <= req_c.wdata & MASK_OUT_MODE;
    end

    // per channel local copies
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            always_ff @(posedge core_clk) begin
                if (bank_rst) loc_q[gi].pwr <= RST_PWR_STATE[1:0];
                else if (wr_ev && hit_p && chsel_q[gi])
                    loc_q[gi].pwr <= req_c.wdata[1:0];
            end
        end
    endgenerate

    // read mux: channel A wins when both selected
    wire [1:0]   loc_rd  = chsel_q[0] ? loc_q[0].pwr : loc_q[1].pwr;
    logic [7:0]  rmux;
    always_comb begin
        case (req_c.addr)
            ADDR_SP_CFG_A:  rmux = cfg_a_q;
            ADDR_SP_CFG_B:  rmux = {single_q, 7'h00};
            ADDR_PWR_STATE: rmux = {6'h00, loc_rd};
            ADDR_FAMILY:    rmux = ID_FAMILY;
            ADDR_PART_LO:   rmux = ID_PART_LO;
            ADDR_PART_HI:   rmux = ID_PART_HI;
            ADDR_GRADE:     rmux = ID_GRADE;
            ADDR_CHAN_SEL:  rmux = {6'h00, chsel_q};
            ADDR_OUT_MODE:  rmux = omode_q;
            default:        rmux = 8'h00;
        endcase
    end

    // read data prefetched from the instruction address seen last access
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_core_q <= 8'h00;
            lsbf_core_q  <= 1'b0;
        end else begin
            rdata_core_q <= rmux;
            lsbf_core_q  <= cfg_a_q[BIT_LSBF_LO];
        end
    end

    // outputs, each straight from its own flip-flop
    always_ff @(posedge core_clk) begin
        if (srst) pwr_state_a <= PWR_NORMAL;
        else pwr_state_a <= loc_q[0].pwr;
    end

    always_ff @(posedge core_clk) begin
        if (srst) pwr_state_b <= PWR_NORMAL;
        else pwr_state_b <= loc_q[1].pwr;
    end

    always_ff @(posedge core_clk) begin
        if (srst) out_mode <= RST_OUT_MODE;
        else out_mode <= omode_q;
    end

    always_ff @(posedge core_clk) begin
        if (srst) lsb_first <= 1'b0;
        else lsb_first <= cfg_a_q[BIT_LSBF_LO];
    end

    always_ff @(posedge core_clk) begin
        if (srst) addr_ascend <= 1'b0;
        else addr_ascend <= cfg_a_q[BIT_ASC_LO];
    end

    // covers the reload cycle too, so the host sees no gap
    always_ff @(posedge core_clk) begin
        if (srst) recovering <= 1'b0;
        else recovering <= (rec_q != '0) || soft_rst_q;
    end

    always_ff @(posedge core_clk) begin
        if (srst) datapath_reset <= 1'b0;
        else datapath_reset <= dp_rst_q;
    end

endmodule

// file: testbench/acrm_regbank_props.sv
// acrm_regbank_props: port-level checks of the configuration bank
// assumes: bound into acrm_regbank, one core clock domain
`timescale 1ns/1ps
module acrm_regbank_props
    import acrm_pkg::*;
#(
    parameter int RECOVER_CYC = SOFT_RST_CYC
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       srst,
    // serial select
    input wire logic       cs_n,
    // device state
    input wire logic [1:0] pwr_state_a,
    input wire logic [1:0] pwr_state_b,
    input wire logic [7:0] out_mode,
    input wire logic       lsb_first,
    input wire logic       addr_ascend,
    input wire logic       recovering,
    input wire logic       datapath_reset
);
    logic [15:0] rec_cnt_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // cycles spent recovering
    always_ff @(posedge core_clk) begin
        if (srst || !recovering)
            rec_cnt_q <= 16'h0000;
        else
            rec_cnt_q <= rec_cnt_q + 16'h0001;
    end
    a_reset_defaults: assert property (
        $fell(srst) |-> out_mode == RST_OUT_MODE && pwr_state_a == PWR_NORMAL && !recovering)
        else $error("defaults missing after reset");
    a_recover_length: assert property (
        $fell(recovering) |-> rec_cnt_q >= RECOVER_CYC && rec_cnt_q <= RECOVER_CYC + 1)
        else $error("recovery time wrong");
    a_recover_bound: assert property (recovering |-> rec_cnt_q <= RECOVER_CYC + 1)
        else $error("recovery overran");
    a_soft_reload: assert property (
        $rose(recovering) |-> ##[0:1] (out_mode == RST_OUT_MODE && pwr_state_a == PWR_NORMAL
        && pwr_state_b == PWR_NORMAL && !lsb_first && !addr_ascend))
        else $error("soft reset did not reload");
    a_recover_frozen: assert property (
        recovering [*3] |-> $stable(out_mode) && $stable(pwr_state_a) && $stable(pwr_state_b))
        else $error("write taken while recovering");
    a_power_codes: assert property (pwr_state_a != 2'h1 && pwr_state_b != 2'h1)
        else $error("illegal power state");
    a_mode_global: assert property ($changed(pwr_state_a) && !recovering |-> $stable(out_mode))
        else $error("local write touched global register");
    // updates land only between frames
    a_frame_closed: assert property (
        $changed(out_mode) || $changed(pwr_state_a) |-> cs_n && $past(cs_n))
        else $error("register changed inside a frame");
    // datapath reset lasts one cycle
    a_dp_single: assert property (datapath_reset |=> !datapath_reset)
        else $error("datapath reset held");
endmodule

bind acrm_regbank acrm_regbank_props #(.RECOVER_CYC(RECOVER_CYC)) u_props (
    .core_clk(core_clk), .srst(srst), .cs_n(cs_n), .pwr_state_a(pwr_state_a),
    .pwr_state_b(pwr_state_b), .out_mode(out_mode), .lsb_first(lsb_first),
    .addr_ascend(addr_ascend), .recovering(recovering), .datapath_reset(datapath_reset));

// file: testbench/acrm_host.sv
// acrm_host: serial host driving frames into the bank
// assumes: sclk 15 ns, stopped and low outside frames, MSB-first data
`timescale 1ns/1ps
module acrm_host (
    // serial pins
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_i,
    input  wire logic sdio_o,
    input  wire logic sdio_oe
);
    logic host_oe;
    logic host_d;
    logic last_q;
    // released line shows inverse of its last level
    assign sdio_i = sdio_oe ? sdio_o : (host_oe ? host_d : ~last_q);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_oe = 1'b0;
        host_d = 1'b0;
        last_q = 1'b0;
    end
    always @(posedge sclk) begin
        last_q <= sdio_i;
    end
    // one access per frame; the task sends the unused instruction bits as zero
    task automatic xfer(input logic rd, input logic [11:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] word;
        word = {rd, 3'h0, addr, wd};
        rdat = 8'h00;
        cs_n = 1'b0;
        host_oe = 1'b1;
        for (int i = 23; i >= 0; i--) begin
            host_oe = !(rd && i < 8);
            host_d = word[i];
            #7.5 sclk = 1'b1;
            if (i < 8)
                rdat[i] = sdio_i;
            #7.5 sclk = 1'b0;
        end
        host_oe = 1'b0;
        #7.5 cs_n = 1'b1;
    endtask
endmodule

// file: testbench/test_adc_config_register_map.sv
// test_adc_config_register_map: directed register-map tests over the serial port
// assumes: acrm_host model, recovery shortened to 20 core cycles
`timescale 1ns/1ps
module test_adc_config_register_map;
    import acrm_pkg::*;
    localparam int REC = 20;
    localparam int LIMIT = 5000;
    logic core_clk, srst, sclk, cs_n, sdio_i, sdio_o, sdio_oe;
    logic lsb_first, addr_ascend, recovering, datapath_reset;
    logic [1:0] pwr_state_a, pwr_state_b;
    logic [7:0] out_mode, v, dummy;
    logic [7:0] ids [4];
    logic [1:0] pw [3];
    logic [7:0] mir [4];
    logic [7:0] mexp [4];
    int miscompares, samples_checked, cycles, dp_seen;

    acrm_regbank #(.RECOVER_CYC(REC)) uut (
        .core_clk(core_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
        .sdio_o(sdio_o), .sdio_oe(sdio_oe), .pwr_state_a(pwr_state_a), .pwr_state_b(pwr_state_b),
        .out_mode(out_mode), .lsb_first(lsb_first), .addr_ascend(addr_ascend),
        .recovering(recovering), .datapath_reset(datapath_reset));
    acrm_host host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (datapath_reset === 1'b1)
            dp_seen++;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // frames spaced well beyond four core cycles
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 host.xfer(1'b0, a, d, dummy);
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    // prefetching read: dummy access, then the real one
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            #1 host.xfer(1'b1, a, 8'h00, d);
            repeat (8) @(posedge core_clk);
            #1;
        end
    endtask

    initial begin
        srst = 1'b1;
        miscompares = 0;
        samples_checked = 0;
        cycles = 0;
        dp_seen = 0;
        ids = '{ID_FAMILY, ID_PART_LO, ID_PART_HI, ID_GRADE};
        pw = '{PWR_STANDBY, PWR_DOWN, PWR_NORMAL};
        mir = '{8'h04, 8'h20, 8'h40, 8'h02};
        mexp = '{8'h01, 8'h01, 8'h02, 8'h02};
        repeat (6) @(posedge core_clk);
        #1 srst = 1'b0;
        check(out_mode, RST_OUT_MODE);
        check({4'h0, pwr_state_b, pwr_state_a}, 8'h00);
        check({6'h00, lsb_first, addr_ascend}, 8'h00);
        rd(ADDR_CHAN_SEL, v);
        check(v, {6'h00, RST_CHAN_SEL});
        rd(ADDR_OUT_MODE, v);
        check(v, RST_OUT_MODE);
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_FAMILY + 12'(i), v);
            check(v, ids[i]);
        end
        rd(12'h007, v);
        check(v, 8'h00);
        wr(ADDR_PART_LO, 8'hFF);
        rd(ADDR_PART_LO, v);
        check(v, ID_PART_LO);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CHAN_SEL, 8'h01);
            wr(ADDR_PWR_STATE, {6'h00, pw[i]});
            wr(ADDR_CHAN_SEL, 8'h02);
            wr(ADDR_PWR_STATE, {6'h00, pw[(i + 1) % 3]});
            check({6'h00, pwr_state_a}, {6'h00, pw[i]});
            check({6'h00, pwr_state_b}, {6'h00, pw[(i + 1) % 3]});
            rd(ADDR_PWR_STATE, v);
            check(v, {6'h00, pw[(i + 1) % 3]});
            wr(ADDR_CHAN_SEL, 8'h03);
            rd(ADDR_PWR_STATE, v);
            check(v, {6'h00, pw[i]});
        end
        wr(ADDR_PWR_STATE, {6'h00, PWR_STANDBY});
        check({4'h0, pwr_state_b, pwr_state_a}, 8'h0A);
        wr(ADDR_CHAN_SEL, 8'h01);
        wr(ADDR_OUT_MODE, 8'h05);
        wr(ADDR_CHAN_SEL, 8'h02);
        check(out_mode, 8'h05);
        rd(ADDR_OUT_MODE, v);
        check(v, 8'h05);
        wr(ADDR_SP_CFG_B, 8'h02);
        check(8'(dp_seen), 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SP_CFG_A, mir[i]);
            check({6'h00, lsb_first, addr_ascend}, mexp[i]);
            wr(ADDR_SP_CFG_A, 8'h00);
            check({6'h00, lsb_first, addr_ascend}, 8'h00);
        end
        wr(ADDR_SP_CFG_A, SOFT_RESET_CODE);
        check({7'h00, recovering}, 8'h01);
        wr(ADDR_OUT_MODE, 8'h0A);
        // host waits for recovery to end; the out_mode write sent during it must be dropped
        for (int i = 0; i < 200 && recovering !== 1'b0; i++)
            @(posedge core_clk);
        #1 check({7'h00, recovering}, 8'h00);
        check(out_mode, RST_OUT_MODE);
        check({4'h0, pwr_state_b, pwr_state_a}, 8'h00);
        rd(ADDR_CHAN_SEL, v);
        check(v, {6'h00, RST_CHAN_SEL});
        rd(ADDR_SP_CFG_A, v);
        check(v, 8'h00);
        finish_test();
    end
endmodule
